// ===== design/output_list_sequencer.sv
// Command interpreter for the current-mode list sequencer, an APB slave.
// Assumes APB signals synchronous to clk; commands are CMD writes using ARG.
`timescale 1ns/1ps
`include "output_list_sequencer_consts.svh"
module output_list_sequencer #(
    parameter int unsigned CYCLES_PER_MS = `CLK_MHZ * 1000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output output_list_sequencer_pkg::sample_t outCurrent,
    output output_list_sequencer_pkg::sample_t outVoltLimit,
    output logic listRunning
);
    import output_list_sequencer_pkg::*;

    sample_t voltTable [0:`VOLT_DEPTH-1];
    sample_t currTable [0:`VOLT_DEPTH-1];
    logic [8:0] orderTable [0:`ORDER_DEPTH-1];
    sample_t rbBuf [0:15];

    logic [9:0] voltPtr, currCount, orderCount, queryPtr;
    logic [31:0] arg, result;
    logic [15:0] holdUs, errCode, voltLimit;
    logic [7:0] errCount;
    sample_t currSet, savedCurrent, prevStep;
    run_mode_t runMode;
    run_state_t runState;
    logic userOrdering, dirDown, quarterScale;
    logic rbActive;
    rb_src_t rbSrc;
    logic [4:0] rbIdx, rbLimit, rbCount;
    logic [9:0] stepPos, runLen;
    logic [13:0] transMs;
    logic transLive;

    logic cmdFire, errRead, errPost;
    logic [15:0] next_errCode;
    logic [4:0] op;
    logic signed [31:0] argS;
    logic stepLoad, stepExpire, transLoad, transExpire, abortRun;
    logic [9:0] effPos, stepIndex, rbAddr;
    logic [31:0] readValue;
    logic [9:0] rbAvail;

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a[1:0] == 2'b00) && (a <= `ADDR_VLIMIT || (a >= `ADDR_RB_BASE && a[7] == 1'b0));
    endfunction : isMapped

    function automatic logic [4:0] rbLimitOf(input logic [9:0] filled, input logic [9:0] start);
        logic [9:0] left;
        left = (start >= filled) ? 10'h0 : filled - start;
        rbLimitOf = (left > 10'(`READBACK_MAX)) ? `READBACK_MAX : left[4:0];
    endfunction : rbLimitOf

    assign pready = 1'b1;
    assign listRunning = (runState != RUN_IDLE);
    assign op = pwdata[4:0];
    assign argS = $signed(arg);
    assign cmdFire = psel && penable && pwrite && paddr == `ADDR_CMD && !rbActive;
    assign errRead = psel && penable && !pwrite && paddr == `ADDR_ERROR;
    assign abortRun = cmdFire && op == `OP_MODE_FIXED && listRunning;

    // Error posting for every command; the command's effect is gated by the same terms below
    always_comb begin
        errPost = 1'b0;
        next_errCode = `ERR_COMMAND;
        if (cmdFire) begin
            unique case (op)
                `OP_SET_QUERY: begin
                    errPost = (arg > 32'(`QUERY_MAX));
                    next_errCode = `ERR_RANGE;
                end
                `OP_ORDER_PUSH: begin
                    errPost = (arg > 32'(`ORDER_VALUE_MAX)) || orderCount == 10'(`ORDER_DEPTH);
                    next_errCode = `ERR_RANGE;
                end
                `OP_VOLT_PUSH, `OP_READ_VOLT, `OP_VOLT_FILL_COUNT: begin
                    errPost = listRunning || currCount != 10'h0 ||
                              (op == `OP_VOLT_PUSH && voltPtr == 10'(`VOLT_DEPTH));
                    next_errCode = (listRunning || currCount != 10'h0) ? `ERR_CONFLICT : `ERR_RANGE;
                end
                `OP_CURRENT_SETPOINT_PUSH: begin
                    errPost = listRunning || currCount == 10'(`VOLT_DEPTH);
                    next_errCode = listRunning ? `ERR_CONFLICT : `ERR_RANGE;
                end
                `OP_SELECT_ORDERING, `OP_FUNC_MODE, `OP_ORDER_BEGIN, `OP_LIST_CLEAR: begin
                    errPost = listRunning;
                    next_errCode = `ERR_CONFLICT;
                end
                `OP_SET_CURRENT: begin
                    errPost = argS > `CURRENT_SETPOINT_MAX || argS < `CURRENT_SETPOINT_MIN ||
                              (quarterScale && argS > `CURRENT_SETPOINT_QUARTER);
                    next_errCode = `ERR_RANGE;
                end
                `OP_MODE_LIST: begin
                    errPost = listRunning || runLen == 10'h0;
                    next_errCode = `ERR_CONFLICT;
                end
                `OP_MODE_TRANS: begin
                    errPost = arg > 32'(`TRANS_MAX_MS) || listRunning;
                    next_errCode = listRunning ? `ERR_CONFLICT : `ERR_RANGE;
                end
                `OP_READ_QUERY, `OP_READ_ORDER, `OP_READ_CURRENT_SETPOINT_TABLE, `OP_READ_CURRENT,
                `OP_SET_DIRECTION, `OP_SCALE_SELECT, `OP_MODE_FIXED: begin
                    errPost = 1'b0;
                end
                default: begin
                    errPost = 1'b1;
                end
            endcase
        end
    end

    // Single-entry error queue with a saturating count of errors since the last read; a new error beats the popping read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            errCode <= 16'h0;
            errCount <= 8'h0;
        end else if (errPost) begin
            errCode <= next_errCode;
            errCount <= errRead ? 8'h1 : ((errCount == 8'hff) ? errCount : errCount + 8'h1);
        end else if (errRead) begin
            errCode <= 16'h0;
            errCount <= 8'h0;
        end
    end

    // Software-written registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arg <= 32'h0;
            holdUs <= `HOLD_US_RESET;
            voltLimit <= 16'h0;
        end else if (psel && penable && pwrite) begin
            if (paddr == `ADDR_ARG) begin
                arg <= pwdata;
            end
            if (paddr == `ADDR_HOLD_US) begin
                holdUs <= pwdata[15:0];
            end
            if (paddr == `ADDR_VLIMIT && !listRunning) begin
                voltLimit <= pwdata[15:0];
            end
        end
    end

    // Table storage
    always_ff @(posedge clk) begin
        if (cmdFire && !errPost) begin
            if (op == `OP_VOLT_PUSH) begin
                voltTable[voltPtr] <= arg[15:0];
            end
            if (op == `OP_CURRENT_SETPOINT_PUSH) begin
                currTable[currCount] <= arg[15:0];
            end
            if (op == `OP_ORDER_PUSH) begin
                orderTable[orderCount[8:0]] <= arg[8:0];
            end
        end
    end

    // Pointers and list configuration
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            voltPtr <= 10'h0;
            currCount <= 10'h0;
            orderCount <= 10'h0;
            queryPtr <= 10'h0;
            userOrdering <= 1'b0;
            dirDown <= 1'b0;
            quarterScale <= 1'b0;
        end else if (cmdFire && !errPost) begin
            unique case (op)
                `OP_SET_QUERY: queryPtr <= arg[9:0];
                `OP_ORDER_BEGIN: orderCount <= 10'h0;
                `OP_ORDER_PUSH: orderCount <= orderCount + 10'h1;
                `OP_VOLT_PUSH: voltPtr <= voltPtr + 10'h1;
                `OP_CURRENT_SETPOINT_PUSH: currCount <= currCount + 10'h1;
                `OP_SELECT_ORDERING: userOrdering <= arg[0];
                `OP_SET_DIRECTION: dirDown <= arg[0];
                `OP_SCALE_SELECT: quarterScale <= (arg[2:0] == 3'h4);
                `OP_FUNC_MODE: quarterScale <= 1'b0;
                `OP_LIST_CLEAR: begin
                    voltPtr <= 10'h0;
                    currCount <= 10'h0;
                    orderCount <= 10'h0;
                    queryPtr <= 10'h0;
                end
                default: begin
                end
            endcase
        end
    end

    // Immediate answers to pointer, count and setpoint queries
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= 32'h0;
        end else if (cmdFire && !errPost) begin
            if (op == `OP_READ_QUERY) begin
                result <= {22'h0, queryPtr};
            end else if (op == `OP_VOLT_FILL_COUNT) begin
                result <= {22'h0, voltPtr};
            end else if (op == `OP_READ_CURRENT) begin
                unique case (arg[1:0])
                    2'h1: result <= `CURRENT_SETPOINT_MAX;
                    2'h2: result <= `CURRENT_SETPOINT_MIN;
                    default: result <= {{16{currSet[15]}}, currSet};
                endcase
            end
        end
    end

    // Readback fill, one entry per cycle; CMD writes are dropped while it runs
    assign rbAddr = queryPtr + 10'(rbIdx);
    always_comb begin
        readValue = 32'h0;
        unique case (rbSrc)
            SRC_ORDER: readValue = {23'h0, orderTable[rbAddr[8:0]]};
            SRC_VOLT: readValue = {16'h0, voltTable[rbAddr]};
            SRC_CURRENT_SETPOINT: readValue = {16'h0, currTable[rbAddr]};
            default: readValue = 32'h0;
        endcase
        unique case (op)
            `OP_READ_ORDER: rbAvail = orderCount;
            `OP_READ_VOLT: rbAvail = voltPtr;
            default: rbAvail = currCount;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rbActive <= 1'b0;
            rbSrc <= SRC_ORDER;
            rbIdx <= 5'h0;
            rbLimit <= 5'h0;
            rbCount <= 5'h0;
        end else if (cmdFire && !errPost &&
                     (op == `OP_READ_ORDER || op == `OP_READ_VOLT || op == `OP_READ_CURRENT_SETPOINT_TABLE)) begin
            rbSrc <= (op == `OP_READ_ORDER) ? SRC_ORDER : ((op == `OP_READ_VOLT) ? SRC_VOLT : SRC_CURRENT_SETPOINT);
            rbLimit <= rbLimitOf(rbAvail, queryPtr);
            rbActive <= (rbLimitOf(rbAvail, queryPtr) != 5'h0);
            rbIdx <= 5'h0;
            rbCount <= 5'h0;
        end else if (rbActive) begin
            rbBuf[rbIdx[3:0]] <= readValue[15:0];
            rbIdx <= rbIdx + 5'h1;
            rbCount <= rbIdx + 5'h1;
            rbActive <= (rbIdx + 5'h1 != rbLimit);
        end
    end

    // Step selection: direction reverses the walk, user ordering maps it through the order table
    assign runLen = userOrdering ? orderCount : currCount;
    assign effPos = dirDown ? (runLen - 10'h1 - stepPos) : stepPos;
    assign stepIndex = userOrdering ? {1'b0, orderTable[effPos[8:0]]} : effPos;
    assign stepLoad = (runState == RUN_LOAD);
    assign transLoad = cmdFire && !errPost && op == `OP_SET_CURRENT && runMode == MODE_TRANS;

    hold_timer stepTimer (
        .clk(clk),
        .reset_n(reset_n),
        .load(stepLoad),
        .cancel(abortRun),
        .loadCount(32'(holdUs) * `CYC_PER_US),
        .expire(stepExpire),
        .active()
    );

    hold_timer transTimer (
        .clk(clk),
        .reset_n(reset_n),
        .load(transLoad),
        .cancel(abortRun),
        .loadCount(32'(transMs) * CYCLES_PER_MS),
        .expire(transExpire),
        .active(transLive)
    );

    // Run state, run mode and list execution
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            runState <= RUN_IDLE;
            runMode <= MODE_FIXED;
            stepPos <= 10'h0;
            transMs <= 14'h0;
        end else if (abortRun) begin
            runState <= RUN_IDLE;
            runMode <= MODE_FIXED;
        end else begin
            unique case (runState)
                RUN_IDLE: begin
                    if (cmdFire && !errPost && op == `OP_MODE_LIST) begin
                        runState <= RUN_LOAD;
                        runMode <= MODE_LIST;
                        stepPos <= 10'h0;
                    end else if (cmdFire && !errPost && op == `OP_MODE_TRANS) begin
                        runMode <= MODE_TRANS;
                        transMs <= arg[13:0];
                    end else if (cmdFire && op == `OP_MODE_FIXED) begin
                        runMode <= MODE_FIXED;
                    end else if (transLoad) begin
                        runMode <= MODE_FIXED;
                    end
                end
                RUN_LOAD: runState <= RUN_HOLD;
                RUN_HOLD: begin
                    if (stepExpire) begin
                        if (stepPos == runLen - 10'h1) begin
                            runState <= RUN_IDLE;
                            runMode <= MODE_FIXED;
                        end else begin
                            stepPos <= stepPos + 10'h1;
                            runState <= RUN_LOAD;
                        end
                    end
                end
            endcase
        end
    end

    // Output current, setpoint and voltage limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            outCurrent <= 16'h0;
            outVoltLimit <= 16'h0;
            currSet <= 16'h0;
            savedCurrent <= 16'h0;
            prevStep <= 16'h0;
        end else if (abortRun) begin
            outCurrent <= 16'h0;
            outVoltLimit <= 16'h0;
        end else if (cmdFire && !errPost && op == `OP_MODE_LIST) begin
            outVoltLimit <= voltLimit;
            prevStep <= outCurrent;
        end else if (stepLoad) begin
            prevStep <= outCurrent;
            outCurrent <= currTable[stepIndex];
        end else if (runState == RUN_HOLD && stepExpire && stepPos == runLen - 10'h1 && runLen > 10'h1) begin
            outCurrent <= prevStep;
        end else if (transLoad) begin
            savedCurrent <= currSet;
            currSet <= arg[15:0];
            outCurrent <= arg[15:0];
        end else if (transExpire) begin
            currSet <= savedCurrent;
            outCurrent <= savedCurrent;
            // A limit write landing on the restore edge must not be lost
            if (!listRunning && psel && penable && pwrite && paddr == `ADDR_VLIMIT) begin
                outVoltLimit <= pwdata[15:0];
            end
        end else if (cmdFire && !errPost && op == `OP_SET_CURRENT) begin
            currSet <= arg[15:0];
            outCurrent <= listRunning ? outCurrent : arg[15:0];
        end else if (!listRunning && psel && penable && pwrite && paddr == `ADDR_VLIMIT) begin
            outVoltLimit <= pwdata[15:0];
        end
    end

    // APB read data and error, captured in the setup phase so the access phase sees flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !isMapped(paddr) || (pwrite && paddr != `ADDR_CMD && paddr != `ADDR_ARG &&
                       paddr != `ADDR_HOLD_US && paddr != `ADDR_VLIMIT);
            prdata <= 32'h0;
            if (!pwrite && isMapped(paddr)) begin
                if (paddr >= `ADDR_RB_BASE) begin
                    prdata <= {16'h0, rbBuf[paddr[5:2]]};
                end else begin
                    unique case (paddr)
                        `ADDR_ARG: prdata <= arg;
                        `ADDR_STATUS: prdata <= {24'h0, errCount != 8'h0, quarterScale, dirDown,
                                                 userOrdering, runMode, listRunning, rbActive};
                        `ADDR_RESULT: prdata <= result;
                        `ADDR_ERROR: prdata <= {8'h0, errCount, errCode};
                        `ADDR_HOLD_US: prdata <= {16'h0, holdUs};
                        `ADDR_OUT_CURRENT: prdata <= {16'h0, outCurrent};
                        `ADDR_OUT_VLIMIT: prdata <= {16'h0, outVoltLimit};
                        `ADDR_RB_COUNT: prdata <= {27'h0, rbCount};
                        `ADDR_VLIMIT: prdata <= {16'h0, voltLimit};
                        default: prdata <= 32'h0;
                    endcase
                end
            end
        end
    end
endmodule : output_list_sequencer

// ===== design/output_list_sequencer_consts.svh
// Offsets, field positions, reset values, command codes and timing counts
// for the list sequencer. Included by the sequencer only; the checker and bench use literal values.
`ifndef OUTPUT_LIST_SEQUENCER_CONSTS_SVH
`define OUTPUT_LIST_SEQUENCER_CONSTS_SVH

`define VOLT_DEPTH 1002
`define ORDER_DEPTH 512
`define ORDER_VALUE_MAX 10'h1ff
`define QUERY_MAX 10'h3e9
`define READBACK_MAX 5'h10

// Error codes, two's complement of -221, -222 and -100
`define ERR_CONFLICT 16'hff23
`define ERR_RANGE 16'hff22
`define ERR_COMMAND 16'hff9c

`define CURRENT_SETPOINT_MAX 32'sh00007fff
`define CURRENT_SETPOINT_MIN 32'shffff8001
`define CURRENT_SETPOINT_QUARTER 32'sh00001fff
`define TRANS_MAX_S 10
`define TRANS_MAX_MS (`TRANS_MAX_S * 1000)
`define CLK_MHZ 200
`define CYC_PER_US 32'd200

// Register byte offsets
`define ADDR_CMD 8'h00
`define ADDR_ARG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RESULT 8'h0c
`define ADDR_ERROR 8'h10
`define ADDR_HOLD_US 8'h14
`define ADDR_OUT_CURRENT 8'h18
`define ADDR_OUT_VLIMIT 8'h1c
`define ADDR_RB_COUNT 8'h20
`define ADDR_VLIMIT 8'h24
`define ADDR_RB_BASE 8'h40

// Command codes written to CMD
`define OP_SET_QUERY 5'h01
`define OP_READ_QUERY 5'h02
`define OP_ORDER_BEGIN 5'h03
`define OP_ORDER_PUSH 5'h04
`define OP_READ_ORDER 5'h05
`define OP_SELECT_ORDERING 5'h06
`define OP_SET_DIRECTION 5'h07
`define OP_VOLT_PUSH 5'h08
`define OP_READ_VOLT 5'h09
`define OP_VOLT_FILL_COUNT 5'h0a
`define OP_CURRENT_SETPOINT_PUSH 5'h0b
`define OP_READ_CURRENT_SETPOINT_TABLE 5'h0c
`define OP_LIST_CLEAR 5'h0d
`define OP_SET_CURRENT 5'h0e
`define OP_READ_CURRENT 5'h0f
`define OP_SCALE_SELECT 5'h10
`define OP_MODE_FIXED 5'h11
`define OP_MODE_LIST 5'h12
`define OP_MODE_TRANS 5'h13
`define OP_FUNC_MODE 5'h14

// STATUS fields
`define ST_BUSY 0
`define ST_RUNNING 1
`define ST_MODE_LO 2
`define ST_ORDERING 4
`define ST_DIR_DOWN 5
`define ST_QUARTER 6
`define ST_ERR_PENDING 7

`define HOLD_US_RESET 16'h03e8

`endif

// ===== design/output_list_sequencer_pkg.sv
// Types shared by the list sequencer, its checker and its bench.
// Assumes the constants header is included where numbers are needed.
package output_list_sequencer_pkg;
    typedef enum logic [1:0] {MODE_FIXED, MODE_LIST, MODE_TRANS} run_mode_t;
    typedef enum logic [1:0] {SRC_ORDER, SRC_VOLT, SRC_CURRENT_SETPOINT} rb_src_t;
    typedef enum logic [1:0] {RUN_IDLE, RUN_LOAD, RUN_HOLD} run_state_t;
    typedef logic [15:0] sample_t;
endpackage : output_list_sequencer_pkg

// ===== design/hold_timer.sv
// Down counter that times one interval in clock cycles.
// Assumes the caller loads a count and watches the one-cycle expire pulse.
`timescale 1ns/1ps
module hold_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic cancel,
    input wire logic [31:0] loadCount,
    output logic expire,
    output logic active
);
    logic [31:0] count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 32'h0;
            active <= 1'b0;
            expire <= 1'b0;
        end else if (cancel) begin
            active <= 1'b0;
            expire <= 1'b0;
        end else if (load) begin
            // A zero count still holds for one cycle
            count <= (loadCount == 32'h0) ? 32'h1 : loadCount;
            active <= 1'b1;
            expire <= 1'b0;
        end else if (active && count <= 32'h1) begin
            active <= 1'b0;
            expire <= 1'b1;
        end else begin
            count <= active ? count - 32'h1 : count;
            expire <= 1'b0;
        end
    end
endmodule : hold_timer

// ===== tb/output_list_sequencer_asserts.sv
// Port checker for the list sequencer.
// Assumes commands act at the APB access edge of a CMD write.
`timescale 1ns/1ps
module output_list_sequencer_asserts
    import output_list_sequencer_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = 200000
) (
    input logic clk,
    input logic reset_n,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input sample_t outCurrent,
    input sample_t outVoltLimit,
    input logic listRunning
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic wrAcc;
    logic startReq;
    logic [15:0] wrLow;
    assign wrAcc = psel && penable && pwrite;
    assign startReq = wrAcc && paddr == 8'h00 && pwdata[4:0] == 5'h12;
    assign wrLow = pwdata[15:0];
    sequence run_op_s(logic [4:0] op);
        listRunning && wrAcc && paddr == 8'h00 && pwdata[4:0] == op;
    endsequence
    sequence idle_op_s(logic [4:0] op);
        !listRunning && wrAcc && paddr == 8'h00 && pwdata[4:0] == op;
    endsequence
    a_abort_zeroes: assert property (run_op_s(5'h11) |=> !listRunning && {outCurrent, outVoltLimit} == 32'h0)
        else $error("abort left output set");
    a_load_refused: assert property (run_op_s(5'h0b) |=> listRunning && $stable(outVoltLimit))
        else $error("load during run disturbed it");
    a_start_cause: assert property ($rose(listRunning) |-> $past(startReq))
        else $error("run began without start");
    a_limit_held: assert property (listRunning |=> outVoltLimit == $past(outVoltLimit) || outVoltLimit == 16'h0)
        else $error("limit moved during run");
    a_reset_fixed: assert property ($rose(reset_n) |-> !listRunning && outCurrent == 16'h0)
        else $error("not fixed after reset");
    a_push_quiet: assert property (idle_op_s(5'h08) |=> $stable(outCurrent) && $stable(outVoltLimit))
        else $error("voltage push moved output");
    a_limit_write: assert property (!listRunning && wrAcc && paddr == 8'h24 |=> outVoltLimit == $past(wrLow))
        else $error("limit write not applied");
    a_ro_refused: assert property (wrAcc && paddr == 8'h08 |-> pready && pslverr)
        else $error("status write not refused");
endmodule : output_list_sequencer_asserts

bind output_list_sequencer output_list_sequencer_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_chk (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .outCurrent(outCurrent), .outVoltLimit(outVoltLimit),
    .listRunning(listRunning));

// ===== tb/host_apb_master.sv
// Host partner: APB master, one transfer at a time.
// Assumes the slave may insert wait states; holds until pready.
`timescale 1ns/1ps
module host_apb_master (
    input logic clk,
    input logic pready,
    input logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask : rd
endmodule : host_apb_master

// ===== tb/test_output_list_sequencer.sv
// Self-checking bench for the list sequencer over APB.
// Assumes CYCLES_PER_MS scaled to 20 and zero-wait slave timing.
`timescale 1ns/1ps
module test_output_list_sequencer;
    import output_list_sequencer_pkg::*;
    logic clk = 0, reset_n = 0, psel, penable, pwrite, pready, pslverr, listRunning;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    sample_t outCurrent, outVoltLimit;
    logic [31:0] rq [3] = '{32'h1fff, 32'h7fff, 32'hffff8001};
    int n_errors = 0, n_compared = 0;
    initial forever #2.5 clk = ~clk;
    output_list_sequencer #(.CYCLES_PER_MS(20)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .outCurrent(outCurrent), .outVoltLimit(outVoltLimit), .listRunning(listRunning));
    host_apb_master i_host (.clk(clk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic res(input string s, input logic [7:0] a, input logic [31:0] e);
        i_host.rd(a, v);
        chk(s, e, v);
    endtask : res
    // Waits out readback fill, since CMD writes while busy are dropped
    task automatic cmd(input logic [4:0] op, input logic [31:0] a);
        i_host.wr(8'h04, a);
        i_host.wr(8'h00, {27'h0, op});
        do i_host.rd(8'h08, v); while (v[0] !== 1'b0);
    endtask : cmd
    task automatic give_verdict;
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        res("status", 8'h08, 0);
        cmd(5'h01, 5);
        cmd(5'h02, 0);
        res("query", 8'h0c, 5);
        cmd(5'h01, 1002);
        res("error", 8'h10, 32'h1ff22);
        for (int i = 0; i < 20; i++) cmd(5'h08, i * 3);
        cmd(5'h0a, 0);
        res("fill", 8'h0c, 20);
        cmd(5'h09, 0);
        res("rbcount", 8'h20, 15);
        for (int k = 0; k < 15; k++) res("volt", 8'(8'h40 + 4 * k), (5 + k) * 3);
        cmd(5'h0d, 0);
        cmd(5'h0a, 0);
        res("fill", 8'h0c, 0);
        for (int i = 1; i < 4; i++) cmd(5'h0b, 100 * i);
        cmd(5'h08, 7);
        res("error", 8'h10, 32'h1ff23);
        cmd(5'h03, 0);
        cmd(5'h04, 2);
        cmd(5'h04, 0);
        cmd(5'h04, 512);
        res("error", 8'h10, 32'h1ff22);
        cmd(5'h05, 0);
        res("rbcount", 8'h20, 2);
        res("order", 8'h40, 2);
        cmd(5'h06, 1);
        i_host.wr(8'h14, 1);
        i_host.wr(8'h24, 32'h55);
        cmd(5'h12, 0);
        chk("vlimit", 32'h55, outVoltLimit);
        cmd(5'h0b, 9);
        res("error", 8'h10, 32'h1ff23);
        repeat (1000) if (listRunning) @(posedge clk);
        chk("current", 300, outCurrent);
        chk("vlimit", 32'h55, outVoltLimit);
        cmd(5'h12, 0);
        cmd(5'h11, 0);
        chk("abort", 0, {outCurrent, outVoltLimit});
        cmd(5'h10, 4);
        cmd(5'h0e, 32'h2000);
        res("error", 8'h10, 32'h1ff22);
        cmd(5'h0e, 32'h1fff);
        chk("current", 32'h1fff, outCurrent);
        for (int q = 0; q < 3; q++) begin
            cmd(5'h0f, q);
            res("readback", 8'h0c, rq[q]);
        end
        cmd(5'h13, 10001);
        res("error", 8'h10, 32'h1ff22);
        cmd(5'h13, 2);
        cmd(5'h0e, 32'h123);
        chk("transient", 32'h123, outCurrent);
        repeat (60) @(posedge clk);
        chk("restore", 32'h1fff, outCurrent);
        cmd(5'h06, 0);
        cmd(5'h07, 1);
        i_host.wr(8'h14, 0);
        cmd(5'h12, 0);
        repeat (100) if (listRunning) @(posedge clk);
        chk("current", 200, outCurrent);
        cmd(5'h0c, 0);
        res("current_setpoint", 8'h48, 300);
        cmd(5'h1f, 0);
        res("error", 8'h10, 32'h1ff9c);
        i_host.wr(8'h08, 32'h0);
        chk("pslverr", 1, pslverr);
        give_verdict();
    end
endmodule : test_output_list_sequencer
